// ===== logic/mts_pkg.sv
// Shared constants and types of the temperature sensor register bank
package mts_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int PTR_W = 8;
  localparam int DATA_W = 16;
  localparam int TEMP_W = 13;
  localparam int LIM_W = 10;
  localparam int CHANNELS = 9;
  localparam int CHAN_W = 4;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] IDX_REMOTE_LAST = 8'h08;
  localparam logic [7:0] IDX_SOFT_RESET = 8'h20;
  localparam logic [7:0] IDX_OVER_STATUS = 8'h21;
  localparam logic [7:0] IDX_HYST = 8'h38;
  localparam logic [7:0] IDX_LOCAL_LIMIT = 8'h39;
  localparam logic [7:0] IDX_REMOTE1_LIMIT = 8'h42;
  localparam logic [7:0] IDX_REMOTE_LAST_LIMIT = 8'h7A;
  localparam logic [7:0] IDX_BLOCK_FIRST = 8'h80;
  localparam logic [7:0] IDX_BLOCK_LAST = 8'h88;
  localparam logic [7:0] IDX_LOCK = 8'hC4;
  localparam logic [7:0] IDX_MAKER_ID = 8'hFE;
  localparam logic [7:0] IDX_PART_ID = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TEMP_LSB = 3;
  localparam int LIM_LSB = 6;
  localparam int LIM_STRIDE_LSB = 3;
  localparam int SOFT_RESET_BIT = 15;
  localparam int STATUS_LSB = 7;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] LOCK_CODE = 16'h5CA6;
  localparam logic [15:0] UNLOCK_CODE = 16'hEB19;
  localparam logic [15:0] LOCKED_READ = 16'h8000;
  localparam logic [15:0] UNLOCKED_READ = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [12:0] TEMP_RESET = 13'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h7FC0;
  localparam logic [15:0] HYST_RESET = 16'h0000;
  localparam logic LOCK_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Core sequencer states, Gray along idle-exec-answer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_ANSWER = 2'h3
  } mts_core_state_e;

endpackage : mts_pkg

// ===== logic/mts_link_if.sv
// Command and answer carrier between the link front end and the core
`timescale 1ns/1ns
interface mts_link_if;
  logic reqToggle;
  logic reqWrite;
  logic reqHasData;
  logic [7:0] reqPtr;
  logic [15:0] reqData;
  logic ackToggle;
  logic [15:0] ackData;

  modport front (
    output reqToggle,
    output reqWrite,
    output reqHasData,
    output reqPtr,
    output reqData,
    input ackToggle,
    input ackData
  );

  modport core (
    input reqToggle,
    input reqWrite,
    input reqHasData,
    input reqPtr,
    input reqData,
    output ackToggle,
    output ackData
  );
endinterface : mts_link_if

// ===== logic/mts_link_front.sv
// Link-clock front end: holds one command and crosses it to the core
`timescale 1ns/1ns
module mts_link_front (
  // Link clock and the core reset
  input wire logic linkClk,
  input wire logic rst_b,
  // Command from the two-wire engine
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic cmdHasData,
  input wire logic [7:0] cmdPtr,
  input wire logic [15:0] cmdData,
  // Answer to the two-wire engine
  output logic cmdBusy,
  output logic rspValid,
  output logic [15:0] rspData,
  // Core side
  mts_link_if.front lnk
);

  logic rstMeta;
  logic rstSync;
  logic ackMeta;
  logic ackSync;
  logic ackSeen;
  logic ackEvent;

  // ----------------------------------------------------------------
  // Reset and answer synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    rstMeta <= rst_b;
    rstSync <= rstMeta;
  end

  always_ff @(posedge linkClk) begin
    if (!rstSync) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
      ackSeen <= 1'b0;
    end else begin
      ackMeta <= lnk.ackToggle;
      ackSync <= ackMeta;
      ackSeen <= ackSync;
    end
  end

  assign ackEvent = ackSync != ackSeen;

  // ----------------------------------------------------------------
  // Request hold; fields stay still until the core has answered
  // ----------------------------------------------------------------
  always_ff @(posedge linkClk) begin
    if (!rstSync) begin
      lnk.reqToggle <= 1'b0;
      lnk.reqWrite <= 1'b0;
      lnk.reqHasData <= 1'b0;
      lnk.reqPtr <= mts_pkg::INDEX_RESET;
      lnk.reqData <= mts_pkg::ZERO_WORD;
      cmdBusy <= 1'b0;
    end else if (cmdValid && !cmdBusy) begin
      lnk.reqToggle <= !lnk.reqToggle;
      lnk.reqWrite <= cmdWrite;
      lnk.reqHasData <= cmdHasData;
      lnk.reqPtr <= cmdPtr;
      lnk.reqData <= cmdData;
      cmdBusy <= 1'b1;
    end else if (ackEvent) begin
      cmdBusy <= 1'b0;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!rstSync) begin
      rspValid <= 1'b0;
      rspData <= mts_pkg::ZERO_WORD;
    end else begin
      rspValid <= ackEvent;
      if (ackEvent) begin
        rspData <= lnk.ackData;
      end
    end
  end

endmodule : mts_link_front

// ===== logic/mts_temp_regs.sv
// Register bank and over-limit status of the nine-channel sensor
`timescale 1ns/1ns

// Notes on behaviour
// - Eight-bit index selects register, loaded on writes
// - Index is zero after reset
// - Writes to unassigned indexes change nothing
// - Unassigned reads answered, data value unspecified
// - 13-bit results in bits 15:3, channels 00h-08h
// - Low four result bits are sixteenths
// - Results read-only, overwritten on each conversion
// - Reads accepted anytime, return last full result
// - Result reads zero before first conversion
// - Block range mirrors results, index auto-increments
// - Lock register codes; read-back shows lock state
// - Reset bit 15 restores power-on values
// - Software reset ignored while locked
// - Reserved reset and status bits read zero
// - Status at 21h: remotes 15:8, local 7
// - Flag sets when temperature exceeds channel limit
// - Flag clears at limit minus hysteresis
// - Low-active alert follows any set flag
// - Fixed maker and part identification words
module mts_temp_regs #(
  parameter logic [15:0] MAKER_ID = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h0101, // Arbitrary value
  parameter int CHANNELS = mts_pkg::CHANNELS
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Link clock
  input wire logic linkClk,
  // Command from the two-wire engine, link clock domain
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic cmdHasData,
  input wire logic [7:0] cmdPtr,
  input wire logic [15:0] cmdData,
  // Answer to the two-wire engine, link clock domain
  output logic cmdBusy,
  output logic rspValid,
  output logic [15:0] rspData,
  // Results from the converter, core clock domain
  input wire logic convValid,
  input wire logic [3:0] convChan,
  input wire logic [12:0] convResult,
  // Over-temperature alert pin
  output logic overTempAlertOut_b
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mts_link_if link ();

  mts_pkg::mts_core_state_e state;
  logic reqMeta;
  logic reqSync;
  logic reqSeen;
  logic reqEvent;
  logic ackToggle;
  logic [15:0] ackData;

  logic [7:0] registerIndex;
  logic [12:0] tempValue [CHANNELS];
  logic [9:0] limitValue [CHANNELS];
  logic [9:0] hystValue;
  logic locked;
  logic softRst;
  logic clearAll;
  logic [CHANNELS-1:0] overFlag;

  logic exec;
  logic execWrite;
  logic execRead;
  logic [4:0] wrLimitSlot;
  logic [15:0] readWord;
  logic [15:0] statusWord;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // Returns {hit, channel} for a limit index: 39h or 42h + 8 * n
  function automatic logic [4:0] limitSlot(input logic [7:0] idx);
    logic [7:0] delta;
    logic [3:0] chan;
    logic hit;
    delta = idx - mts_pkg::IDX_REMOTE1_LIMIT;
    chan = 4'h0;
    hit = 1'b0;
    if (idx == mts_pkg::IDX_LOCAL_LIMIT) begin
      hit = 1'b1;
    end else if (idx >= mts_pkg::IDX_REMOTE1_LIMIT &&
                 idx <= mts_pkg::IDX_REMOTE_LAST_LIMIT &&
                 delta[2:0] == 3'h0) begin
      hit = 1'b1;
      chan = delta[6:3] + 4'h1;
    end
    limitSlot = {hit, chan};
  endfunction : limitSlot

  // Returns {hit, channel} for a result index, direct or block mirror
  function automatic logic [4:0] tempSlot(input logic [7:0] idx);
    logic [7:0] delta;
    logic [4:0] slot;
    delta = idx - mts_pkg::IDX_BLOCK_FIRST;
    slot = 5'h00;
    if (idx <= mts_pkg::IDX_REMOTE_LAST) begin
      slot = {1'b1, idx[3:0]};
    end else if (idx >= mts_pkg::IDX_BLOCK_FIRST &&
                 idx <= mts_pkg::IDX_BLOCK_LAST) begin
      slot = {1'b1, delta[3:0]};
    end
    tempSlot = slot;
  endfunction : tempSlot

  // ----------------------------------------------------------------
  // Link front end on the link clock
  // ----------------------------------------------------------------
  mts_link_front u_front (
    .linkClk(linkClk),
    .rst_b(rst_b),
    .cmdValid(cmdValid),
    .cmdWrite(cmdWrite),
    .cmdHasData(cmdHasData),
    .cmdPtr(cmdPtr),
    .cmdData(cmdData),
    .cmdBusy(cmdBusy),
    .rspValid(rspValid),
    .rspData(rspData),
    .lnk(link.front)
  );

  assign link.ackToggle = ackToggle;
  assign link.ackData = ackData;

  // ----------------------------------------------------------------
  // Request crossing and sequencer
  // ----------------------------------------------------------------
  // Request fields are only sampled once the toggle has crossed, so
  // they have been still for at least two core edges by then.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
    end else begin
      reqMeta <= link.reqToggle;
      reqSync <= reqMeta;
    end
  end

  assign reqEvent = reqSync != reqSeen;

  // The sequencer is untouched by software reset, so the command that
  // requested it still gets its answer.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= mts_pkg::ST_IDLE;
      reqSeen <= 1'b0;
      ackToggle <= 1'b0;
      ackData <= mts_pkg::ZERO_WORD;
    end else begin
      case (state)
        mts_pkg::ST_IDLE: begin
          if (reqEvent) begin
            reqSeen <= reqSync;
            state <= mts_pkg::ST_EXEC;
          end
        end
        mts_pkg::ST_EXEC: begin
          ackData <= readWord;
          state <= mts_pkg::ST_ANSWER;
        end
        mts_pkg::ST_ANSWER: begin
          ackToggle <= !ackToggle;
          state <= mts_pkg::ST_IDLE;
        end
        default: begin
          state <= mts_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign exec = state == mts_pkg::ST_EXEC;
  assign execWrite = exec && link.reqWrite && link.reqHasData;
  assign execRead = exec && !link.reqWrite;
  assign wrLimitSlot = limitSlot(link.reqPtr);
  assign clearAll = !rst_b || softRst;

  // ----------------------------------------------------------------
  // Register index
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      registerIndex <= mts_pkg::INDEX_RESET;
    end else if (exec && link.reqWrite) begin
      registerIndex <= link.reqPtr;
    end else if (execRead && registerIndex >= mts_pkg::IDX_BLOCK_FIRST &&
                 registerIndex <= mts_pkg::IDX_BLOCK_LAST) begin
      // Past the last mirror the walk wraps to the first one
      if (registerIndex == mts_pkg::IDX_BLOCK_LAST) begin
        registerIndex <= mts_pkg::IDX_BLOCK_FIRST;
      end else begin
        registerIndex <= registerIndex + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Temperature results, written only by the converter
  // ----------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_temp
      always_ff @(posedge ref_clk) begin
        if (clearAll) begin
          tempValue[ch] <= mts_pkg::TEMP_RESET;
        end else if (convValid && convChan == 4'(ch)) begin
          tempValue[ch] <= convResult;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Limits and hysteresis; frozen while locked
  // ----------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_limit
      always_ff @(posedge ref_clk) begin
        if (clearAll) begin
          limitValue[ch] <=
            mts_pkg::LIMIT_RESET[mts_pkg::DATA_W-1:mts_pkg::LIM_LSB];
        end else if (execWrite && !locked && wrLimitSlot[4] &&
                     wrLimitSlot[3:0] == 4'(ch)) begin
          limitValue[ch] <=
            link.reqData[mts_pkg::DATA_W-1:mts_pkg::LIM_LSB];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      hystValue <= mts_pkg::HYST_RESET[mts_pkg::DATA_W-1:mts_pkg::LIM_LSB];
    end else if (execWrite && !locked &&
                 link.reqPtr == mts_pkg::IDX_HYST) begin
      hystValue <= link.reqData[mts_pkg::DATA_W-1:mts_pkg::LIM_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Lock and software reset
  // ----------------------------------------------------------------
  // Other data written to the lock index leaves the state alone
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      locked <= mts_pkg::LOCK_RESET;
    end else if (execWrite && link.reqPtr == mts_pkg::IDX_LOCK) begin
      if (link.reqData == mts_pkg::LOCK_CODE) begin
        locked <= 1'b1;
      end else if (link.reqData == mts_pkg::UNLOCK_CODE) begin
        locked <= 1'b0;
      end
    end
  end

  // One-cycle pulse; on the next edge it clears the index, results, limits, hysteresis and flags, and sets the lock
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      softRst <= 1'b0;
    end else begin
      softRst <= execWrite && !locked &&
                 link.reqPtr == mts_pkg::IDX_SOFT_RESET &&
                 link.reqData[mts_pkg::SOFT_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Over-limit flags with hysteresis
  // ----------------------------------------------------------------
  // Compared as signed values on the 13-bit result grid; the release
  // point is one bit wider so that a low limit cannot wrap upward.
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_flag
      logic signed [13:0] tempS;
      logic signed [13:0] limitS;
      logic signed [14:0] releaseS;
      assign tempS = {tempValue[ch][12], tempValue[ch]};
      assign limitS = {limitValue[ch][9], limitValue[ch], 3'h0};
      assign releaseS = $signed({limitS[13], limitS}) -
                        $signed({2'h0, hystValue, 3'h0});
      always_ff @(posedge ref_clk) begin
        if (clearAll) begin
          overFlag[ch] <= 1'b0;
        end else if (tempS > limitS) begin
          overFlag[ch] <= 1'b1;
        end else if (tempS <= releaseS) begin
          overFlag[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // The pin lags the flags by one edge so it comes from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      overTempAlertOut_b <= 1'b1;
    end else begin
      overTempAlertOut_b <= !(|overFlag);
    end
  end

  // Remote n sits at bit 7 + n, local at bit 7, the rest stay zero
  assign statusWord = {overFlag, {mts_pkg::STATUS_LSB{1'b0}}};

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] tSlot;
    logic [4:0] lSlot;
    tSlot = tempSlot(registerIndex);
    lSlot = limitSlot(registerIndex);
    readWord = mts_pkg::UNMAPPED_READ;
    if (tSlot[4]) begin
      readWord = {tempValue[tSlot[3:0]], {mts_pkg::TEMP_LSB{1'b0}}};
    end else if (lSlot[4]) begin
      readWord = {limitValue[lSlot[3:0]], {mts_pkg::LIM_LSB{1'b0}}};
    end else begin
      case (registerIndex)
        mts_pkg::IDX_SOFT_RESET: begin
          readWord = mts_pkg::ZERO_WORD;
        end
        mts_pkg::IDX_OVER_STATUS: begin
          readWord = statusWord;
        end
        mts_pkg::IDX_HYST: begin
          readWord = {hystValue, {mts_pkg::LIM_LSB{1'b0}}};
        end
        mts_pkg::IDX_LOCK: begin
          readWord = locked ? mts_pkg::LOCKED_READ : mts_pkg::UNLOCKED_READ;
        end
        mts_pkg::IDX_MAKER_ID: begin
          readWord = MAKER_ID;
        end
        mts_pkg::IDX_PART_ID: begin
          readWord = PART_ID;
        end
        default: begin
          readWord = mts_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

endmodule : mts_temp_regs

// ===== testbench/mts_host_model.sv
// Host model that issues register commands on the link
`timescale 1ns/1ns
module mts_host_model (
  // Link clock
  input wire logic linkClk,
  // Command to the block
  output logic cmdValid,
  output logic cmdWrite,
  output logic cmdHasData,
  output logic [7:0] cmdPtr,
  output logic [15:0] cmdData,
  // Answer from the block
  input wire logic cmdBusy,
  input wire logic rspValid,
  input wire logic [15:0] rspData
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdHasData = 1'b0;
    cmdPtr = 8'h00;
    cmdData = 16'h0000;
  end

  // Offer on a falling edge, hold until taken, then await the answer
  task automatic xfer(input logic wr, input logic hd, input logic [7:0] p,
      input logic [15:0] d, input int gap, output logic [15:0] rd,
      output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    repeat (gap) @(negedge linkClk);
    @(negedge linkClk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdHasData <= hd;
    cmdPtr <= p;
    cmdData <= d;
    // Busy is settled between edges, so the next rising edge takes it
    for (n = 0; n < 20 && cmdBusy !== 1'b0; n++) @(negedge linkClk);
    @(posedge linkClk);
    @(negedge linkClk);
    // Released fields flip so that no stale value can pass for valid
    cmdValid <= 1'b0;
    cmdWrite <= ~wr;
    cmdHasData <= ~hd;
    cmdPtr <= ~p;
    cmdData <= ~d;
    for (n = 0; n < 20 && ok == 1'b0; n++) begin
      @(negedge linkClk);
      if (rspValid === 1'b1) begin
        ok = 1'b1;
        rd = rspData;
      end
    end
  endtask : xfer
endmodule : mts_host_model

// ===== testbench/mts_temp_regs_chk.sv
// Port checks of the sensor register bank
`timescale 1ns/1ns
module mts_temp_regs_chk #(
  parameter int CHANNELS = mts_pkg::CHANNELS
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic linkClk,
  // Link command side
  input wire logic cmdValid,
  input wire logic cmdBusy,
  input wire logic rspValid,
  input wire logic [15:0] rspData,
  // Alert pin
  input wire logic overTempAlertOut_b
);
  // The link side leaves reset two link edges after rst_b; until then
  // its outputs may still be unknown, so link checks wait a third edge
  logic [2:0] linkRstSh;
  logic linkUp;
  always_ff @(posedge linkClk) begin
    if (!rst_b) begin
      linkRstSh <= 3'h0;
    end else begin
      linkRstSh <= {linkRstSh[1:0], 1'h1};
    end
  end
  assign linkUp = linkRstSh[2];

  cmd_take_a: assert property (@(posedge linkClk)
    disable iff (!rst_b || !linkUp)
    cmdValid && !cmdBusy |=> cmdBusy) else $error("busy missing after take");
  rsp_bound_a: assert property (@(posedge linkClk)
    disable iff (!rst_b || !linkUp)
    cmdValid && !cmdBusy |-> ##[1:10] rspValid) else $error("no answer");
  rsp_pulse_a: assert property (@(posedge linkClk)
    disable iff (!rst_b || !linkUp)
    rspValid |=> !rspValid) else $error("answer longer than one cycle");
  busy_end_a: assert property (@(posedge linkClk)
    disable iff (!rst_b || !linkUp)
    $fell(cmdBusy) |-> rspValid) else $error("busy dropped without answer");
  busy_cause_a: assert property (@(posedge linkClk)
    disable iff (!rst_b || !linkUp)
    $rose(cmdBusy) |-> $past(cmdValid)) else $error("busy without command");
  data_hold_a: assert property (@(posedge linkClk)
    disable iff (!rst_b || !linkUp)
    !$stable(rspData) |-> rspValid) else $error("read word moved");
  reset_quiet_a: assert property (@(posedge linkClk)
    disable iff (!rst_b || !linkUp)
    $rose(linkUp) |-> (!cmdBusy && !rspValid && rspData == 16'h0000) [*2])
    else $error("link outputs not idle after reset");
  alert_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> overTempAlertOut_b [*3])
    else $error("alert active after reset");
endmodule : mts_temp_regs_chk

bind mts_temp_regs mts_temp_regs_chk #(.CHANNELS(CHANNELS)) u_chk (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .linkClk(linkClk),
  .cmdValid(cmdValid),
  .cmdBusy(cmdBusy),
  .rspValid(rspValid),
  .rspData(rspData),
  .overTempAlertOut_b(overTempAlertOut_b)
);

// ===== testbench/mts_temp_regs_tb.sv
// Self-checking bench of the nine-channel sensor register bank
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[FAIL] %s exp %h got %h", nm, exp, got); \
    end \
  end
module mts_temp_regs_tb;
  localparam logic [15:0] MAKER = 16'h0A5A; // Arbitrary value
  localparam logic [15:0] PART = 16'h0203; // Arbitrary value
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_b = 1'b0;
  logic convValid = 1'b0;
  logic [3:0] convChan = 4'h0;
  logic [12:0] convResult = 13'h0000;
  logic cmdValid, cmdWrite, cmdHasData, cmdBusy, rspValid, alert_b;
  logic [7:0] cmdPtr;
  logic [15:0] cmdData, rspData;
  int err_total = 0;
  int checked = 0;
  int hostGap = 3;

  // --------
  // Design and host
  // --------
  mts_temp_regs #(.MAKER_ID(MAKER), .PART_ID(PART)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .linkClk(linkClk),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdHasData(cmdHasData),
    .cmdPtr(cmdPtr), .cmdData(cmdData), .cmdBusy(cmdBusy),
    .rspValid(rspValid), .rspData(rspData), .convValid(convValid),
    .convChan(convChan), .convResult(convResult),
    .overTempAlertOut_b(alert_b));
  mts_host_model u_host (
    .linkClk(linkClk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdHasData(cmdHasData), .cmdPtr(cmdPtr), .cmdData(cmdData),
    .cmdBusy(cmdBusy), .rspValid(rspValid), .rspData(rspData));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Link clock has no phase relation to the core clock
  initial begin
    #7;
    forever #32 linkClk = ~linkClk;
  end

  // --------
  // Helpers
  // --------
  function automatic logic [15:0] tw(input int v);
    return {13'(v), 3'b000};
  endfunction : tw
  task automatic wrap_up();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic cmd(input logic wr, input logic hd, input logic [7:0] p,
      input logic [15:0] d, output logic [15:0] r);
    logic ok;
    u_host.xfer(wr, hd, p, d, hostGap, r, ok);
    `CHK("answer", 1'b1, ok)
    if (ok !== 1'b1) wrap_up();
  endtask : cmd
  task automatic wrr(input logic [7:0] p, input logic [15:0] d);
    logic [15:0] r;
    cmd(1'b1, 1'b1, p, d, r);
  endtask : wrr
  task automatic rdx(input logic [15:0] e, input string nm);
    logic [15:0] r;
    cmd(1'b0, 1'b0, 8'h00, 16'h0000, r);
    `CHK(nm, e, r)
  endtask : rdx
  task automatic rdp(input logic [7:0] p, input logic [15:0] e,
      input string nm);
    logic [15:0] r;
    cmd(1'b1, 1'b0, p, 16'h0000, r);
    rdx(e, nm);
  endtask : rdp
  task automatic conv(input int ch, input int v);
    @(negedge ref_clk);
    convValid = 1'b1;
    convChan = 4'(ch);
    convResult = 13'(v);
    @(negedge ref_clk);
    convValid = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : conv

  // --------
  // Scenarios
  // --------
  task automatic t_power_on();
    rdx(16'h0000, "index0");
    rdp(8'hFE, MAKER, "maker");
    wrr(8'hFE, 16'hFFFF);
    rdx(MAKER, "maker ro");
    rdp(8'hFF, PART, "part");
    rdp(8'hC4, 16'h8000, "lock");
    rdp(8'h20, 16'h0000, "swreset");
    rdp(8'h21, 16'h0000, "status");
    rdp(8'h05, 16'h0000, "temp5");
    rdp(8'h10, 16'h0000, "unmapped");
  endtask : t_power_on
  task automatic t_results();
    hostGap = 0;
    for (int i = 0; i < 9; i++) conv(i, 161 + 16 * i);
    rdp(8'h00, 16'h0508, "fraction");
    for (int i = 1; i < 9; i++) rdp(8'(i), tw(161 + 16 * i), "temp");
    wrr(8'h00, 16'hFFF8);
    rdx(16'h0508, "read only");
    conv(0, 480);
    rdx(tw(480), "update");
    rdp(8'h87, tw(273), "block7");
    rdx(tw(289), "block8");
    rdx(tw(480), "wrap");
  endtask : t_results
  task automatic t_lock();
    wrr(8'hC4, 16'h1234);
    rdx(16'h8000, "bad code");
    wrr(8'hC4, 16'hEB19);
    rdx(16'h0000, "unlocked");
    wrr(8'hC4, 16'h5CA6);
    rdx(16'h8000, "locked");
    wrr(8'h20, 16'h8000);
    rdp(8'h00, tw(480), "locked reset");
    wrr(8'hC4, 16'hEB19);
    wrr(8'h20, 16'h7FFF);
    rdp(8'h00, tw(480), "reset bit0");
    wrr(8'h20, 16'h8000);
    rdp(8'h00, 16'h0000, "reset temp");
    rdp(8'hC4, 16'h8000, "relock");
  endtask : t_lock
  task automatic t_limit();
    wrr(8'hC4, 16'hEB19);
    wrr(8'h10, 16'h5CA6);
    rdp(8'hC4, 16'h0000, "unmapped write");
    wrr(8'h39, 16'h0C80);
    rdx(16'h0C80, "limit");
    wrr(8'h7A, 16'h0C80);
    wrr(8'h38, 16'h0100);
    conv(0, 400);
    `CHK("at limit", 1'b1, alert_b)
    conv(0, 401);
    `CHK("over", 1'b0, alert_b)
    rdp(8'h21, 16'h0080, "local flag");
    conv(8, 416);
    conv(0, 369);
    rdx(16'h8080, "in band");
    conv(0, 368);
    rdx(16'h8000, "local clear");
    `CHK("one over", 1'b0, alert_b)
    conv(8, 0);
    `CHK("all clear", 1'b1, alert_b)
  endtask : t_limit

  initial begin
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(posedge linkClk);
    t_power_on();
    t_results();
    t_lock();
    t_limit();
    wrap_up();
  end
endmodule : mts_temp_regs_tb
